// File: hdl/rfs_top.sv
// rfs_top: register file, stack sequencer and external bus strobe generator
//
// Function
// - 144 locations: ports, general, control
// - sources read, destinations written
// - any location by 8-bit address
// - pointer group plus 4-bit designator
// - pointer written by writes or set-pointer
// - mode bit picks internal or external stack
// - external stack uses 16-bit pointer
// - internal stack uses low pointer byte only
// - call pushes pc; interrupt pushes pc, flags
// - internal pop reads any location except write-only; push writes general only
// - returns pop pc, or flags then pc
// - address strobe pulses for every transfer
// - address strobe opens every machine cycle
// - strobes and port buses float together
// - data strobe once; write data held
// - data strobe as sync before opcode, only with external memory off
// - read/write low only for writes
// - reset starts at program location 000c
// - next opcode fetched during execution
// - under reset: strobe pulses, ports input
module rfs_top import rfs_pkg::*; #(
   parameter int DS_CYCLES = RFS_DS_CYCLES
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // register port
   input wire rfs_reg_req_t i_reg,
   output logic [7:0] o_reg_rdata,
   // stack and data sequencer
   input wire logic i_seq_valid,
   input wire rfs_seq_req_t i_seq,
   output logic o_seq_ready,
   output logic o_seq_done,
   output logic [7:0] o_seq_data,
   // instruction fetch
   input wire logic i_opcode_next,
   input wire logic i_op_ready,
   output logic o_op_valid,
   output logic [7:0] o_op_byte,
   output logic [15:0] o_pc,
   output logic [10:0] o_rom_addr,
   input wire logic [7:0] i_rom_data,
   // status
   output logic [7:0] o_mode,
   // bus pins
   output logic o_address_strobe_n,
   output logic o_data_strobe_n,
   output logic o_read_write_n,
   output logic o_ctl_oe_n,
   output logic [7:0] o_ad_out,
   output logic o_ad_oe_n,
   input wire logic [7:0] i_ad_in,
   output logic [7:0] o_addr_hi,
   output logic o_addr_hi_oe_n
);
   typedef struct packed {
      rfs_state_t st;
      rfs_op_t op;
      logic [1:0] cnt;
      logic [3:0] tcnt;
      logic bus_fetch;
      logic bus_ext;
      logic bus_wr;
      logic [15:0] bus_addr;
      logic [7:0] bus_wdata;
      logic [15:0] pc;
      logic [15:0] save_pc;
      logic [15:0] target;
      logic [7:0] data;
      logic [7:0] hold_byte;
      logic hold_valid;
      logic done;
      logic [7:0] rdata;
      rfs_pins_t pins;
      rfs_rf_t rf;
   } rfs_top_st_t;

   rfs_top_st_t q;
   rfs_top_st_t d;
   logic [7:0] ad_sync;

   rfs_sync3 #(
      .WIDTH(8)
   ) u_ad_sync (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_async(i_ad_in),
      .o_level(ad_sync)
   );

   function automatic logic [7:0] eff_addr(logic work, logic [7:0] a, logic [7:0] rp);
      return work ? {rp[7:4], a[3:0]} : a;
   endfunction : eff_addr

   function automatic logic [7:0] rf_rd(rfs_rf_t rf, logic [7:0] a);
      logic [7:0] v;
      v = RFS_HIDDEN_READ;
      if (!a[7]) begin
         v = rf.lo[a[6:0]];
      end else if (a[7:4] == RFS_CTL_GROUP && !RFS_WO_MASK[a[3:0]]) begin
         v = rf.ctl[a[3:0]];
      end
      return v;
   endfunction : rf_rd

   function automatic rfs_rf_t rf_wr(rfs_rf_t rf, logic [7:0] a, logic [7:0] v);
      rfs_rf_t r;
      r = rf;
      if (!a[7]) begin
         r.lo[a[6:0]] = v;
      end else if (a[7:4] == RFS_CTL_GROUP) begin
         r.ctl[a[3:0]] = v;
      end
      return r;
   endfunction : rf_wr

   function automatic logic [1:0] op_len(rfs_op_t op);
      logic [1:0] n;
      case (op)
         RFS_OP_PUSH, RFS_OP_POP: n = 2'd1;
         RFS_OP_CALL, RFS_OP_RET: n = 2'd2;
         RFS_OP_INTR, RFS_OP_INTERRUPT_RETURN: n = 2'd3;
         default: n = 2'd0;
      endcase
      return n;
   endfunction : op_len

   function automatic logic is_pop(rfs_op_t op);
      return (op == RFS_OP_POP) || (op == RFS_OP_RET) || (op == RFS_OP_INTERRUPT_RETURN);
   endfunction : is_pop

   always_comb begin
      logic [7:0] rp;
      logic [7:0] mode;
      logic [15:0] sp;
      logic [7:0] spl_m;
      logic [7:0] v;
      logic [7:0] pb;
      logic pop_now;
      logic ext_mem;
      logic in_cyc;
      rp = '0;
      mode = '0;
      sp = '0;
      spl_m = '0;
      v = '0;
      pb = '0;
      pop_now = 1'b0;
      ext_mem = 1'b0;
      in_cyc = 1'b0;
      d = q;
      d.done = 1'b0;
      rp = q.rf.ctl[RFS_PTR_ADDR[3:0]];
      mode = q.rf.ctl[RFS_MODE_ADDR[3:0]];
      sp = {q.rf.ctl[RFS_SPH_ADDR[3:0]], q.rf.ctl[RFS_SPL_ADDR[3:0]]};
      spl_m = sp[7:0] - 8'h01;

      if (i_reg.src_rd) begin
         d.rdata = rf_rd(q.rf, eff_addr(i_reg.src_work, i_reg.src_addr, rp));
      end
      if (i_reg.dst_wr) begin
         d.rf = rf_wr(d.rf, eff_addr(i_reg.dst_work, i_reg.dst_addr, rp), i_reg.wdata);
      end
      if (i_reg.set_ptr) begin
         d.rf.ctl[RFS_PTR_ADDR[3:0]] = i_reg.ptr_val;
      end
      if (q.hold_valid && i_op_ready) begin
         d.hold_valid = 1'b0;
      end

      // stacked byte order: pc low, pc high, then flags
      case (q.op)
         RFS_OP_CALL: pb = (q.cnt == 2'd2) ? q.save_pc[7:0] : q.save_pc[15:8];
         RFS_OP_INTR: begin
            if (q.cnt == 2'd3) begin
               pb = q.save_pc[7:0];
            end else if (q.cnt == 2'd2) begin
               pb = q.save_pc[15:8];
            end else begin
               pb = q.rf.ctl[RFS_FLAGS_ADDR[3:0]];
            end
         end
         default: pb = q.data;
      endcase

      case (q.st)
         RFS_IDLE: begin
            if (i_seq_valid) begin
               d.op = i_seq.op;
               d.data = i_seq.data;
               d.save_pc = i_seq.save_pc;
               d.target = i_seq.target;
               d.cnt = op_len(i_seq.op);
               d.bus_fetch = 1'b0;
               if (i_seq.op == RFS_OP_DATA) begin
                  d.bus_ext = 1'b1;
                  d.bus_wr = i_seq.write;
                  d.bus_addr = i_seq.addr;
                  d.bus_wdata = i_seq.data;
                  d.st = RFS_T1;
               end else begin
                  d.st = RFS_STEP;
               end
            end else if (!q.hold_valid) begin
               d.bus_fetch = 1'b1;
               d.bus_wr = 1'b0;
               d.bus_addr = q.pc;
               d.bus_ext = mode[RFS_MODE_EXT_MEM] && (q.pc >= RFS_EXT_BASE);
               d.st = i_opcode_next ? RFS_SYNC : RFS_T1;
            end
         end
         RFS_SYNC: d.st = RFS_T1;
         RFS_T1: begin
            d.tcnt = 4'(DS_CYCLES - 1);
            d.st = RFS_T2;
         end
         RFS_T2: begin
            if (q.tcnt == 4'h0) begin
               d.st = RFS_T3;
            end else begin
               d.tcnt = q.tcnt - 4'h1;
            end
         end
         RFS_T3: begin
            v = (q.bus_fetch && !q.bus_ext) ? i_rom_data : ad_sync;
            if (q.bus_fetch) begin
               d.hold_byte = v;
               d.hold_valid = 1'b1;
               d.pc = q.pc + 16'h0001;
               d.st = RFS_IDLE;
            end else if (q.op == RFS_OP_DATA) begin
               if (!q.bus_wr) begin
                  d.data = v;
               end
               d.done = 1'b1;
               d.st = RFS_IDLE;
            end else begin
               pop_now = !q.bus_wr;
               d.cnt = q.cnt - 2'd1;
               d.st = RFS_STEP;
            end
         end
         RFS_STEP: begin
            if (q.cnt == 2'd0) begin
               if (q.op inside {RFS_OP_CALL, RFS_OP_INTR, RFS_OP_RET, RFS_OP_INTERRUPT_RETURN}) begin
                  d.pc = q.target;
                  d.hold_valid = 1'b0;
               end
               d.done = 1'b1;
               d.st = RFS_IDLE;
            end else if (!mode[RFS_MODE_INT_STACK]) begin
               d.bus_fetch = 1'b0;
               d.bus_ext = 1'b1;
               d.bus_wr = !is_pop(q.op);
               d.bus_wdata = pb;
               d.bus_addr = is_pop(q.op) ? sp : sp - 16'h0001;
               {d.rf.ctl[RFS_SPH_ADDR[3:0]], d.rf.ctl[RFS_SPL_ADDR[3:0]]} =
                  is_pop(q.op) ? sp + 16'h0001 : sp - 16'h0001;
               d.st = RFS_T1;
            end else begin
               if (is_pop(q.op)) begin
                  pop_now = 1'b1;
                  v = rf_rd(q.rf, sp[7:0]);
                  d.rf.ctl[RFS_SPL_ADDR[3:0]] = sp[7:0] + 8'h01;
               end else begin
                  // an internal push outside the general area is dropped, the pointer still moves
                  if (spl_m >= RFS_GP_FIRST && spl_m <= RFS_GP_LAST) begin
                     d.rf = rf_wr(d.rf, spl_m, pb);
                  end
                  d.rf.ctl[RFS_SPL_ADDR[3:0]] = spl_m;
               end
               d.cnt = q.cnt - 2'd1;
            end
         end
         default: d.st = RFS_IDLE;
      endcase

      if (pop_now) begin
         case (q.op)
            RFS_OP_POP: d.data = v;
            RFS_OP_RET: begin
               if (q.cnt == 2'd2) begin
                  d.target[15:8] = v;
               end else begin
                  d.target[7:0] = v;
               end
            end
            RFS_OP_INTERRUPT_RETURN: begin
               if (q.cnt == 2'd3) begin
                  d.rf.ctl[RFS_FLAGS_ADDR[3:0]] = v;
               end else if (q.cnt == 2'd2) begin
                  d.target[15:8] = v;
               end else begin
                  d.target[7:0] = v;
               end
            end
            default: d.data = q.data;
         endcase
      end

      // pins follow the next state so that they leave flip-flops aligned with it
      ext_mem = d.rf.ctl[RFS_MODE_ADDR[3:0]][RFS_MODE_EXT_MEM];
      in_cyc = (d.st == RFS_T1) || (d.st == RFS_T2) || (d.st == RFS_T3);
      d.pins.as_n = (d.st != RFS_T1);
      if (ext_mem) begin
         d.pins.ds_n = !((d.st == RFS_T2) && d.bus_ext);
      end else begin
         d.pins.ds_n = (d.st != RFS_SYNC);
      end
      d.pins.rw_n = !(in_cyc && d.bus_ext && d.bus_wr);
      d.pins.ad_out = (d.st == RFS_T1) ? d.bus_addr[7:0] : d.bus_wdata;
      d.pins.ad_oe_n = !(ext_mem && ((d.st == RFS_T1) ||
                                     (in_cyc && d.bus_ext && d.bus_wr)));
      d.pins.hi_out = d.bus_addr[15:8];
      d.pins.hi_oe_n = !(ext_mem && in_cyc);
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '0;
         q.st <= RFS_IDLE;
         q.op <= RFS_OP_NONE;
         q.pc <= RFS_RESET_PC;
         q.pins <= RFS_PINS_IDLE;
         q.rf.ctl[RFS_MODE_ADDR[3:0]] <= RFS_MODE_RESET;
      end else begin
         q <= d;
      end
   end

   logic float_q;
   assign float_q = q.rf.ctl[RFS_MODE_ADDR[3:0]][RFS_MODE_FLOAT];

   // reset holds the pins combinationally; the strobe then copies the clock
   assign o_address_strobe_n = !i_rst_b ? i_mclk : q.pins.as_n;
   assign o_data_strobe_n = i_rst_b & q.pins.ds_n;
   assign o_read_write_n = !i_rst_b | q.pins.rw_n;
   assign o_ctl_oe_n = i_rst_b & float_q;
   assign o_ad_out = q.pins.ad_out;
   assign o_ad_oe_n = !i_rst_b | float_q | q.pins.ad_oe_n;
   assign o_addr_hi = q.pins.hi_out;
   assign o_addr_hi_oe_n = !i_rst_b | float_q | q.pins.hi_oe_n;

   assign o_reg_rdata = q.rdata;
   assign o_seq_ready = (q.st == RFS_IDLE);
   assign o_seq_done = q.done;
   assign o_seq_data = q.data;
   assign o_op_valid = q.hold_valid;
   assign o_op_byte = q.hold_byte;
   assign o_pc = q.pc;
   assign o_rom_addr = q.bus_addr[10:0];
   assign o_mode = q.rf.ctl[RFS_MODE_ADDR[3:0]];
endmodule : rfs_top

// File: hdl/rfs_pkg.sv
// rfs_pkg: constants and carrier types for the register file, stack and bus strobes
package rfs_pkg;
   // register file geometry
   localparam int RFS_LO_LOCS = 128;
   localparam int RFS_CTL_LOCS = 16;
   localparam logic [7:0] RFS_GP_FIRST = 8'h04;
   localparam logic [7:0] RFS_GP_LAST = 8'h7f;
   localparam logic [3:0] RFS_CTL_GROUP = 4'hf;
   localparam logic [7:0] RFS_HIDDEN_READ = 8'h00;
   // control locations
   localparam logic [7:0] RFS_MODE_ADDR = 8'hf8;
   localparam logic [7:0] RFS_FLAGS_ADDR = 8'hfc;
   localparam logic [7:0] RFS_PTR_ADDR = 8'hfd;
   localparam logic [7:0] RFS_SPH_ADDR = 8'hfe;
   localparam logic [7:0] RFS_SPL_ADDR = 8'hff;
   localparam logic [15:0] RFS_WO_MASK = 16'h00ff;
   // mode control fields
   localparam int RFS_MODE_INT_STACK = 2;
   localparam int RFS_MODE_EXT_MEM = 4;
   localparam int RFS_MODE_FLOAT = 7;
   localparam logic [7:0] RFS_MODE_RESET = 8'h00;
   // program space
   localparam logic [15:0] RFS_RESET_PC = 16'h000c;
   localparam logic [15:0] RFS_EXT_BASE = 16'h0800;
   // timing
   localparam int RFS_CLK_MHZ = 50;
   localparam int RFS_DS_NS = 80;
   localparam int RFS_DS_CYCLES = (RFS_DS_NS * RFS_CLK_MHZ + 999) / 1000;
   localparam int RFS_RESET_HOLD_CLKS = 18;

   typedef enum logic [2:0] {
      RFS_IDLE = 3'b000,
      RFS_SYNC = 3'b001,
      RFS_T1 = 3'b011,
      RFS_T2 = 3'b010,
      RFS_T3 = 3'b110,
      RFS_STEP = 3'b100
   } rfs_state_t;

   typedef enum logic [2:0] {
      RFS_OP_NONE = 3'h0,
      RFS_OP_PUSH = 3'h1,
      RFS_OP_POP = 3'h2,
      RFS_OP_CALL = 3'h3,
      RFS_OP_INTR = 3'h4,
      RFS_OP_RET = 3'h5,
      RFS_OP_INTERRUPT_RETURN = 3'h6,
      RFS_OP_DATA = 3'h7
   } rfs_op_t;

   typedef struct packed {
      logic src_rd;
      logic src_work;
      logic [7:0] src_addr;
      logic dst_wr;
      logic dst_work;
      logic [7:0] dst_addr;
      logic [7:0] wdata;
      logic set_ptr;
      logic [7:0] ptr_val;
   } rfs_reg_req_t;

   typedef struct packed {
      rfs_op_t op;
      logic write;
      logic [15:0] addr;
      logic [7:0] data;
      logic [15:0] save_pc;
      logic [15:0] target;
   } rfs_seq_req_t;

   typedef struct packed {
      logic as_n;
      logic ds_n;
      logic rw_n;
      logic [7:0] ad_out;
      logic ad_oe_n;
      logic [7:0] hi_out;
      logic hi_oe_n;
   } rfs_pins_t;

   typedef struct packed {
      logic [RFS_CTL_LOCS-1:0][7:0] ctl;
      logic [RFS_LO_LOCS-1:0][7:0] lo;
   } rfs_rf_t;

   localparam rfs_pins_t RFS_PINS_IDLE = '{
      as_n: 1'b1, ds_n: 1'b1, rw_n: 1'b1, ad_out: 8'h00,
      ad_oe_n: 1'b1, hi_out: 8'h00, hi_oe_n: 1'b1};
endpackage : rfs_pkg

// File: hdl/rfs_sync3.sv
// rfs_sync3: three-stage pin synchroniser whose level moves only when stages two and three agree
module rfs_sync3 import rfs_pkg::*; #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // pin side
   input wire logic [WIDTH-1:0] i_async,
   // clocked side
   output logic [WIDTH-1:0] o_level
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } rfs_sync_st_t;

   rfs_sync_st_t q;
   rfs_sync_st_t d;

   always_comb begin
      d = q;
      d.s1 = i_async;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // s1 feeds s2 only, so a metastable sample never reaches the compare
      if (q.s2 == q.s3) begin
         d.lvl = q.s3;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_level = q.lvl;
endmodule : rfs_sync3

// File: sim/rfs_checker_sva.sv
// rfs_checker_sva: concurrent checks on the strobe pins and status outputs of rfs_top
module rfs_checker_sva import rfs_pkg::*; #(
   parameter int DS_CYCLES = RFS_DS_CYCLES
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // watched outputs
   input wire logic [15:0] o_pc,
   input wire logic [7:0] o_mode,
   input wire logic o_address_strobe_n,
   input wire logic o_data_strobe_n,
   input wire logic o_read_write_n,
   input wire logic o_ctl_oe_n,
   input wire logic [7:0] o_ad_out,
   input wire logic o_ad_oe_n,
   input wire logic o_addr_hi_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   logic [7:0] ds_low_q;
   // strobe length is a parameter, so it is counted here rather than unrolled
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ds_low_q <= 8'h00;
      end else begin
         ds_low_q <= o_data_strobe_n ? 8'h00 : ds_low_q + 8'h01;
      end
   end
   ds_len_ext_a: assert property (o_mode[RFS_MODE_EXT_MEM] && $rose(o_data_strobe_n)
      |-> ds_low_q == DS_CYCLES) else $error("data strobe length wrong");
   ds_after_as_a: assert property (o_mode[RFS_MODE_EXT_MEM] && $fell(o_data_strobe_n)
      |-> $past(o_address_strobe_n) == 1'b0) else $error("data strobe without address strobe");
   as_one_cycle_a: assert property ($fell(o_address_strobe_n) |=> o_address_strobe_n)
      else $error("address strobe not a single cycle");
   rw_write_span_a: assert property ($fell(o_read_write_n) |-> !o_address_strobe_n
      ##1 !o_read_write_n [*5] ##1 o_read_write_n) else $error("write span wrong");
   wdata_held_a: assert property (!o_read_write_n && !o_data_strobe_n
      && !$past(o_data_strobe_n) |-> $stable(o_ad_out) && !o_ad_oe_n)
      else $error("write data moved under data strobe");
   sync_before_as_a: assert property (!o_mode[RFS_MODE_EXT_MEM] && $fell(o_data_strobe_n)
      |=> o_data_strobe_n && $fell(o_address_strobe_n)) else $error("sync pulse misplaced");
   float_ctl_a: assert property ($stable(o_mode[RFS_MODE_FLOAT])
      |-> o_ctl_oe_n == o_mode[RFS_MODE_FLOAT]) else $error("strobe enable wrong");
   float_bus_a: assert property (o_mode[RFS_MODE_FLOAT] && $past(o_mode[RFS_MODE_FLOAT])
      |-> o_ad_oe_n && o_addr_hi_oe_n) else $error("bus driven while floating");
   reset_pc_a: assert property ($rose(i_rst_b) |-> o_pc == RFS_RESET_PC)
      else $error("start address wrong");
   reset_pins_a: assert property (disable iff (1'b0) !i_rst_b |-> !o_data_strobe_n
      && o_read_write_n && o_ad_oe_n && o_addr_hi_oe_n) else $error("pins wrong in reset");
   cover property ($fell(o_read_write_n));
   cover property (!o_mode[RFS_MODE_EXT_MEM] && $fell(o_data_strobe_n));
   cover property (o_mode[RFS_MODE_EXT_MEM] && $rose(o_data_strobe_n));
   cover property (o_mode[RFS_MODE_FLOAT]);
endmodule : rfs_checker_sva

// File: sim/rfs_mem_model.sv
// rfs_mem_model: external program and data memory on the multiplexed bus
module rfs_mem_model (
   // bus from the device
   input wire logic i_as_n,
   input wire logic i_ds_n,
   input wire logic i_rw_n,
   input wire logic [7:0] i_ad,
   input wire logic i_ad_oe_n,
   input wire logic [7:0] i_hi,
   // resolved port 1 level
   output logic [7:0] o_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cells [0:65535];
   logic [15:0] bus_dly;
   logic [15:0] addr_q;
   initial begin
      for (int i = 0; i < 65536; i++) begin
         cells[i] = i[7:0] ^ i[15:8];
      end
   end
   // delayed copy: address is only promised up to the strobe's trailing edge
   always @(i_ad or i_hi) bus_dly <= #1 {i_hi, i_ad};
   always @(posedge i_as_n) addr_q <= bus_dly;
   always @(posedge i_ds_n) if (!i_rw_n) cells[addr_q] <= bus_dly[7:0];
   // released bus shows the inverse so a stale value never passes
   assign o_pin = !i_ad_oe_n ? i_ad : (!i_ds_n && i_rw_n) ? cells[addr_q] : ~i_ad;
endmodule : rfs_mem_model

// File: sim/register_file_stack_bus_strobes_test.sv
// register_file_stack_bus_strobes_test: directed bench for rfs_top
module register_file_stack_bus_strobes_test import rfs_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_mclk, i_rst_b, i_seq_valid, i_opcode_next, i_op_ready;
   rfs_reg_req_t i_reg;
   rfs_seq_req_t i_seq;
   logic [7:0] o_reg_rdata, o_seq_data, o_op_byte, o_mode, o_ad_out, o_addr_hi, i_rom_data, pin;
   logic o_seq_ready, o_seq_done, o_op_valid, o_address_strobe_n, o_data_strobe_n;
   logic o_read_write_n, o_ctl_oe_n, o_ad_oe_n, o_addr_hi_oe_n;
   logic [15:0] o_pc;
   logic [10:0] o_rom_addr;
   int fail_count, n_checks;
   assign i_rom_data = o_rom_addr[7:0] ^ 8'h5a;
   rfs_top #(.DS_CYCLES(4)) uut (.i_mclk, .i_rst_b, .i_reg, .o_reg_rdata, .i_seq_valid, .i_seq,
      .o_seq_ready, .o_seq_done, .o_seq_data, .i_opcode_next, .i_op_ready, .o_op_valid,
      .o_op_byte, .o_pc, .o_rom_addr, .i_rom_data, .o_mode, .o_address_strobe_n,
      .o_data_strobe_n, .o_read_write_n, .o_ctl_oe_n, .o_ad_out, .o_ad_oe_n, .i_ad_in(pin),
      .o_addr_hi, .o_addr_hi_oe_n);
   rfs_mem_model ext (.i_as_n(o_address_strobe_n), .i_ds_n(o_data_strobe_n),
      .i_rw_n(o_read_write_n), .i_ad(o_ad_out), .i_ad_oe_n(o_ad_oe_n), .i_hi(o_addr_hi),
      .o_pin(pin));
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(posedge i_mclk);
      i_reg <= '{dst_wr: 1'b1, dst_work: w, dst_addr: a, wdata: d, default: '0};
      @(posedge i_mclk);
      i_reg <= '0;
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic w);
      @(posedge i_mclk);
      i_reg <= '{src_rd: 1'b1, src_work: w, src_addr: a, default: '0};
      @(posedge i_mclk);
      i_reg <= '0;
      #1;
      chk(o_reg_rdata, e);
   endtask : rchk
   task automatic seq(input rfs_op_t op, input logic [15:0] a, input logic [7:0] d,
      input logic w, output int n);
      logic r;
      @(posedge i_mclk);
      i_seq_valid <= 1'b1;
      i_seq <= '{op: op, write: w, addr: a, data: d, save_pc: a, target: 16'h0010};
      do begin
         #1 r = o_seq_ready;
         @(posedge i_mclk);
      end while (r !== 1'b1);
      i_seq_valid <= 1'b0;
      for (n = 1; n < 60; n++) begin
         @(posedge i_mclk);
         #1;
         if (o_seq_done === 1'b1) break;
      end
      chk(o_seq_done, 1'b1);
   endtask : seq
   task automatic wait_op();
      repeat (40) begin
         @(posedge i_mclk);
         #1;
         if (o_op_valid === 1'b1) break;
      end
   endtask : wait_op
   task automatic t_reset();
      repeat (5) @(posedge i_mclk);
      #1;
      chk({o_data_strobe_n, o_read_write_n, o_ad_oe_n, o_addr_hi_oe_n}, 4'h7);
      chk(o_pc, RFS_RESET_PC);
      chk(o_address_strobe_n, 1'b1);
      @(negedge i_mclk);
      #1;
      chk(o_address_strobe_n, 1'b0);
      repeat (5) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      $display("test reset done");
   endtask : t_reset
   task automatic t_fetch();
      wait_op();
      chk(o_op_byte, 8'h0c ^ 8'h5a);
      chk(o_pc, 16'h000d);
      @(posedge i_mclk);
      i_op_ready <= 1'b1;
      // an operand byte next, so the fetch runs without the sync cycle
      i_opcode_next <= 1'b0;
      @(posedge i_mclk);
      i_op_ready <= 1'b0;
      wait_op();
      chk(o_op_byte, 8'h0d ^ 8'h5a);
      @(posedge i_mclk);
      i_opcode_next <= 1'b1;
      $display("test fetch done");
   endtask : t_fetch
   task automatic t_regs();
      rchk(RFS_MODE_ADDR, RFS_MODE_RESET, 1'b0);
      wr(8'h04, 8'h11, 1'b0);
      wr(8'h7f, 8'h22, 1'b0);
      wr(8'h80, 8'h33, 1'b0);
      rchk(8'h04, 8'h11, 1'b0);
      rchk(8'h7f, 8'h22, 1'b0);
      rchk(8'h80, RFS_HIDDEN_READ, 1'b0);
      wr(RFS_PTR_ADDR, 8'h70, 1'b0);
      wr(8'h05, 8'h5c, 1'b1);
      rchk(8'h75, 8'h5c, 1'b0);
      rchk(8'h05, 8'h5c, 1'b1);
      @(posedge i_mclk);
      i_reg <= '{set_ptr: 1'b1, ptr_val: 8'h10, default: '0};
      @(posedge i_mclk);
      i_reg <= '0;
      rchk(RFS_PTR_ADDR, 8'h10, 1'b0);
      wr(RFS_MODE_ADDR, 8'h80, 1'b0);
      repeat (2) @(posedge i_mclk);
      #1;
      chk({o_ctl_oe_n, o_ad_oe_n, o_addr_hi_oe_n}, 3'h7);
      wr(RFS_MODE_ADDR, 8'h00, 1'b0);
      $display("test registers done");
   endtask : t_regs
   task automatic t_stacks();
      int n;
      wr(RFS_MODE_ADDR, 8'h10, 1'b0);
      seq(RFS_OP_DATA, 16'h0923, 8'ha5, 1'b1, n);
      // edges after the take: one address cycle, four strobe cycles, one sample cycle
      chk(n[15:0], 16'd6);
      chk(ext.cells[16'h0923], 8'ha5);
      seq(RFS_OP_DATA, 16'h0a42, 8'h00, 1'b0, n);
      chk(o_seq_data, 8'h42 ^ 8'h0a);
      wr(RFS_MODE_ADDR, 8'h14, 1'b0);
      wr(RFS_SPL_ADDR, 8'h40, 1'b0);
      seq(RFS_OP_CALL, 16'h1234, 8'h00, 1'b0, n);
      rchk(8'h3f, 8'h34, 1'b0);
      rchk(8'h3e, 8'h12, 1'b0);
      rchk(RFS_SPL_ADDR, 8'h3e, 1'b0);
      seq(RFS_OP_RET, 16'h0000, 8'h00, 1'b0, n);
      chk(o_pc, 16'h1234);
      wr(RFS_FLAGS_ADDR, 8'h9a, 1'b0);
      seq(RFS_OP_INTR, 16'h0456, 8'h00, 1'b0, n);
      rchk(8'h3d, 8'h9a, 1'b0);
      rchk(8'h3e, 8'h04, 1'b0);
      wr(RFS_FLAGS_ADDR, 8'h00, 1'b0);
      seq(RFS_OP_INTERRUPT_RETURN, 16'h0000, 8'h00, 1'b0, n);
      rchk(RFS_FLAGS_ADDR, 8'h9a, 1'b0);
      rchk(RFS_SPL_ADDR, 8'h40, 1'b0);
      seq(RFS_OP_PUSH, 16'h0000, 8'h77, 1'b0, n);
      seq(RFS_OP_POP, 16'h0000, 8'h00, 1'b0, n);
      chk(o_seq_data, 8'h77);
      wr(RFS_MODE_ADDR, 8'h10, 1'b0);
      wr(RFS_SPH_ADDR, 8'h20, 1'b0);
      wr(RFS_SPL_ADDR, 8'h00, 1'b0);
      seq(RFS_OP_CALL, 16'hbeef, 8'h00, 1'b0, n);
      chk({ext.cells[16'h1ffe], ext.cells[16'h1fff]}, 16'hbeef);
      rchk(RFS_SPH_ADDR, 8'h1f, 1'b0);
      rchk(RFS_SPL_ADDR, 8'hfe, 1'b0);
      $display("test stacks done");
   endtask : t_stacks
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      i_rst_b = 1'b0;
      i_reg = '0;
      i_seq = '0;
      i_seq_valid = 1'b0;
      i_opcode_next = 1'b1;
      i_op_ready = 1'b0;
      t_reset();
      t_fetch();
      t_regs();
      t_stacks();
      wrap_up();
   end
   // whole run needs well under 2000 cycles; this cuts a hung handshake short
   initial begin
      repeat (30000) @(posedge i_mclk);
      fail_count++;
      wrap_up();
   end
endmodule : register_file_stack_bus_strobes_test
bind rfs_top rfs_checker_sva #(.DS_CYCLES(DS_CYCLES)) u_chk (.i_mclk, .i_rst_b, .o_pc, .o_mode,
   .o_address_strobe_n, .o_data_strobe_n, .o_read_write_n, .o_ctl_oe_n, .o_ad_out, .o_ad_oe_n,
   .o_addr_hi_oe_n);
